/* core/mrs_pkg.sv */
// Purpose: Shared constants for the module reset sequencer
// Assumes: 20 MHz system clock, low-frequency oscillator enable derived by divider
// Notes: Times kept in microseconds; filter tick count derived from them, reset tail given in cycles
package mrs_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int LF_HZ = 32768;
   // Divider from system clock to the low-frequency filter tick
   localparam int LF_DIV = CLK_HZ / LF_HZ;
   // Qualification window: at least 1.5 ms, at most 4.0 ms after pin goes low
   localparam int FILT_MIN_US = 1500;
   localparam int FILT_MAX_US = 4000;
   localparam int PIN_HOLD_US = 5000;
   // Ticks needed: round up the least time
   localparam int FILT_TICKS = (FILT_MIN_US * LF_HZ + 999999) / 1000000;
   // Count reloaded for the reset tail while a request stands, in system cycles
   localparam int RST_HOLD_CYC = 16;
   localparam int GP_WIDTH = 8;
   localparam int CNT_W = 16;
   // Request source bit positions in the cause vector
   localparam int SRC_POR = 0;
   localparam int SRC_PIN = 1;
   localparam int SRC_WDT = 2;
   localparam int SRC_LV = 3;
   localparam int SRC_SYS = 4;
   localparam int SRC_CPU = 5;
   localparam int SRC_CHIP = 6;
   localparam int SRC_N = 7;
   typedef enum logic [2:0] {
      MRS_POR = 3'h1,
      MRS_RUN = 3'h2,
      MRS_HOLD = 3'h4
   } mrs_state_t;
endpackage

/* core/mrs_pin_filter.sv */
// Purpose: Digital glitch filter on the external reset line
// Assumes: Input already synchronised; tick is a one-cycle low-frequency enable
// Notes: Counts only on ticks, so the delay is set by the slow oscillator rate
`timescale 1ns/1ps
module mrs_pin_filter import mrs_pkg::*; #(
   parameter int TICKS = FILT_TICKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Filter inputs
   input wire logic tick,
   input wire logic line_low,
   // Filtered request
   output logic qualified
);
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic qualified_next;
   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TICKS);
   wire at_limit = (count_reg >= LIMIT);
   assign count_next = !line_low ? '0 :
                       (tick && !at_limit) ? count_reg + 16'h0001 : count_reg;
   assign qualified_next = line_low && at_limit;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
         qualified <= 1'b0;
      end else begin
         count_reg <= count_next;
         qualified <= qualified_next;
      end
   end
endmodule

/* core/mrs_top.sv */
// Purpose: Gathers reset requests and drives the system reset and safe pin state
// Assumes: Request inputs other than the pin are on clk; the pin is asynchronous
// Notes: Reset output is held while any request stands plus a short tail
`timescale 1ns/1ps
module mrs_top import mrs_pkg::*; #(
   parameter int GPW = GP_WIDTH,
   parameter int DIV = LF_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // External reset pin
   input wire logic external_reset_line,
   output logic pin_reset_source_pullup_en,
   // On-chip requesters
   input wire logic watchdog_timeout_reset,
   input wire logic low_voltage_reset,
   input wire logic system_reset_request,
   input wire logic cpu_reset_request,
   input wire logic whole_chip_soft_reset,
   // Reset outputs
   output logic sys_reset_n,
   output logic [SRC_N-1:0] reset_cause,
   // General-purpose pin safe state
   output logic [GPW-1:0] gp_oe_allow,
   output logic [GPW-1:0] gp_pullup_en
);
   logic sync1_reg;
   logic sync2_reg;
   logic [CNT_W-1:0] div_reg;
   logic tick_reg;
   logic pin_qualified;
   mrs_state_t state_reg;
   mrs_state_t state_next;
   logic [CNT_W-1:0] hold_reg;
   logic [CNT_W-1:0] hold_next;
   logic [SRC_N-1:0] cause_next;

   // Two stages for the asynchronous pin; sync1 feeds only sync2
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= external_reset_line;
         sync2_reg <= sync1_reg;
      end
   end

   // Low-frequency enable standing in for the slow oscillator
   wire div_wrap = (div_reg == CNT_W'(DIV - 1));
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= div_wrap ? '0 : div_reg + 16'h0001;
         tick_reg <= div_wrap;
      end
   end

   wire line_low = !sync2_reg;

   mrs_pin_filter #(.TICKS(FILT_TICKS)) u_filter (
      .clk(clk),
      .reset_n(reset_n),
      .tick(tick_reg),
      .line_low(line_low),
      .qualified(pin_qualified)
   );

   wire [SRC_N-1:0] req_vec = {whole_chip_soft_reset, cpu_reset_request,
                               system_reset_request, low_voltage_reset,
                               watchdog_timeout_reset, pin_qualified, 1'b0};
   wire any_req = |req_vec;
   wire hold_done = (hold_reg == '0);

   // Reset held while a request stands, then a fixed tail before release
   always_comb begin
      state_next = state_reg;
      hold_next = hold_reg;
      cause_next = reset_cause;
      case (state_reg)
         MRS_POR: begin
            state_next = MRS_HOLD;
            hold_next = CNT_W'(RST_HOLD_CYC);
         end
         MRS_RUN: begin
            if (any_req) begin
               state_next = MRS_HOLD;
               hold_next = CNT_W'(RST_HOLD_CYC);
               cause_next = req_vec;
            end
         end
         MRS_HOLD: begin
            cause_next = reset_cause | req_vec;
            if (any_req) begin
               hold_next = CNT_W'(RST_HOLD_CYC);
            end else if (!hold_done) begin
               hold_next = hold_reg - 16'h0001;
            end else begin
               state_next = MRS_RUN;
            end
         end
         default: begin
            state_next = MRS_HOLD;
            hold_next = CNT_W'(RST_HOLD_CYC);
         end
      endcase
   end

   wire in_reset_next = (state_next != MRS_RUN);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= MRS_POR;
         hold_reg <= '0;
         reset_cause <= 7'h01;
         sys_reset_n <= 1'b0;
         gp_oe_allow <= '0;
         gp_pullup_en <= '1;
         pin_reset_source_pullup_en <= 1'b1;
      end else begin
         state_reg <= state_next;
         hold_reg <= hold_next;
         reset_cause <= cause_next;
         sys_reset_n <= !in_reset_next;
         gp_oe_allow <= in_reset_next ? '0 : '1;
         gp_pullup_en <= in_reset_next ? '1 : '0;
         pin_reset_source_pullup_en <= 1'b1;
      end
   end
endmodule

/* dv/mrs_top_props.sv */
// Purpose: Port assertions for the reset sequencer
// Assumes: DIV equals the bound instance
// Notes: Pin bounds scale with DIV
`timescale 1ns/1ps
module mrs_top_props import mrs_pkg::*; #(
   parameter int GPW = GP_WIDTH,
   parameter int DIV = LF_DIV
) (
   input wire logic clk, reset_n, external_reset_line, pin_reset_source_pullup_en,
   input wire logic watchdog_timeout_reset, low_voltage_reset, system_reset_request,
   input wire logic cpu_reset_request, whole_chip_soft_reset, sys_reset_n,
   input wire logic [SRC_N-1:0] reset_cause,
   input wire logic [GPW-1:0] gp_oe_allow, gp_pullup_en
);
   localparam int LO_MIN = (FILT_TICKS - 1) * DIV;
   localparam int LO_MAX = (FILT_TICKS + 1) * DIV + 6;
   logic [15:0] low_cnt;
   wire req = watchdog_timeout_reset | low_voltage_reset | system_reset_request |
      cpu_reset_request | whole_chip_soft_reset;
   // Restarts on any high so only a continuous low counts
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) low_cnt <= '0;
      else low_cnt <= external_reset_line ? '0 : low_cnt + 16'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_pin_due;
      low_cnt == LO_MAX;
   endsequence
   a_onchip_enter: assert property (req |-> ##[1:2] !sys_reset_n)
      else $error("on-chip request did not reset");
   a_pin_pullup: assert property (pin_reset_source_pullup_en)
      else $error("pin pull-up off");
   a_short_low: assert property ($fell(sys_reset_n) && !$past(req) && !$past(req, 2)
      |-> low_cnt >= LO_MIN)
      else $error("pin reset taken too early");
   a_pin_taken: assert property (s_pin_due |-> !sys_reset_n)
      else $error("pin reset taken too late");
   a_safe_pins: assert property (!sys_reset_n |-> gp_oe_allow == '0 && gp_pullup_en == '1)
      else $error("pins not safe in reset");
   a_run_pins: assert property (sys_reset_n |-> gp_oe_allow == '1 && gp_pullup_en == '0)
      else $error("pins still safe in run");
endmodule
bind mrs_top mrs_top_props #(.GPW(GPW), .DIV(DIV)) u_props (.*);

/* dv/mrs_board_model.sv */
// Purpose: Board button on the external reset line
// Assumes: Line has a pull-up
// Notes: Released line reads high, never the last value
`timescale 1ns/1ps
module mrs_board_model (
   input wire logic clk,
   output wire logic external_reset_line
);
   logic press_low = 1'b0;
   assign external_reset_line = press_low ? 1'b0 : 1'b1;
   task automatic press(input int n);
      @(posedge clk) press_low <= 1'b1;
      repeat (n) @(posedge clk);
      press_low <= 1'b0;
   endtask
endmodule

/* dv/mrs_top_tb.sv */
// Purpose: Self-checking bench for the reset sequencer
// Assumes: DIV shortened to 2
// Notes: Pin bounds derived from FILT_TICKS and DIV
`timescale 1ns/1ps
module mrs_top_tb import mrs_pkg::*;;
   localparam int D = 2;
   localparam int LO = (FILT_TICKS - 1) * D;
   localparam int HI = (FILT_TICKS + 1) * D + 6;
   logic clk = 0, reset_n = 0, sys_reset_n;
   logic [4:0] req = '0;
   logic [SRC_N-1:0] cause;
   logic [7:0] oe, pu;
   logic pull;
   wire line;
   int n_errors = 0, samples_checked = 0;
   initial forever #25 clk = ~clk;
   mrs_board_model board (.clk(clk), .external_reset_line(line));
   mrs_top #(.DIV(D)) dut (.clk(clk), .reset_n(reset_n), .external_reset_line(line),
      .pin_reset_source_pullup_en(pull), .watchdog_timeout_reset(req[0]),
      .low_voltage_reset(req[1]), .system_reset_request(req[2]), .cpu_reset_request(req[3]),
      .whole_chip_soft_reset(req[4]), .sys_reset_n(sys_reset_n), .reset_cause(cause),
      .gp_oe_allow(oe), .gp_pullup_en(pu));
   task check(input string nm, input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task wait_rel;
      int k;
      k = 0;
      while (sys_reset_n !== 1'b1 && k < 400) begin
         @(posedge clk);
         k++;
      end
      @(posedge clk);
      check("release", k < 400, 1'b1);
      check("oe run", oe, 8'hFF);
      check("pu run", pu, 8'h00);
      check("pin pullup", pull, 1'b1);
   endtask
   task t_por;
      check("cause por", {1'b0, cause}, 8'h01);
      check("oe por", oe, 8'h00);
      check("pu por", pu, 8'hFF);
      reset_n <= 1'b1;
      wait_rel();
   endtask
   task t_req;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) req <= 5'h01 << i;
         @(posedge clk) req <= 5'h00;
         repeat (2) @(posedge clk);
         check("sys reset", sys_reset_n, 1'b0);
         check("cause", cause[SRC_WDT + i], 1'b1);
         wait_rel();
      end
   endtask
   task t_short;
      board.press(LO - 10);
      repeat (6) @(posedge clk);
      board.press(LO - 10);
      repeat (20) @(posedge clk);
      check("short low", sys_reset_n, 1'b1);
   endtask
   task t_long;
      int n;
      n = 0;
      // Board holds the pin well past the window
      fork board.press(HI + 40); join_none
      while (sys_reset_n === 1'b1 && n < HI + 20) begin
         @(posedge clk);
         n++;
      end
      check("pin delay", n >= LO && n <= HI, 1'b1);
      check("pin cause", cause[SRC_PIN], 1'b1);
      wait_rel();
   endtask
   initial begin
      repeat (6) @(posedge clk);
      t_por();
      t_req();
      t_short();
      t_long();
      wrap_up();
   end
   initial begin
      #500000;
      n_errors++;
      wrap_up();
   end
endmodule
